/* onved_regs.svh */
`ifndef ONVED_REGS_SVH
`define ONVED_REGS_SVH

// Register byte offsets on the bus
`define ONVED_OFS_DESC 8'h00
`define ONVED_OFS_CTRL 8'h04
`define ONVED_OFS_TARGET 8'h08
`define ONVED_OFS_CMDS 8'h0c
`define ONVED_OFS_STATUS 8'h10
`define ONVED_OFS_PUBLISH 8'h14

// Descriptor word layout (CTRL reuses positions 31 to 24)
`define ONVED_BIT_AVAIL 31
`define ONVED_BIT_POL 30
`define ONVED_BIT_OTP 29
`define ONVED_BIT_ADDRD 28
`define ONVED_BIT_BYTE1 27
`define ONVED_POS_HI 26
`define ONVED_POS_LO 24
`define ONVED_LOC_HI 23
`define ONVED_LOC_LO 16
`define ONVED_BIT_MODE_OD 23
`define ONVED_BIT_MODE_OS 22
`define ONVED_BIT_MODE_QSD 21
`define ONVED_BIT_MODE_QS 20
`define ONVED_DUM_HI 19
`define ONVED_DUM_LO 16
`define ONVED_RDCMD_HI 15
`define ONVED_RDCMD_LO 8
`define ONVED_WRCMD_HI 7
`define ONVED_WRCMD_LO 0

// Control fields below the descriptor flags
`define ONVED_AW_HI 1
`define ONVED_AW_LO 0
`define ONVED_BIT_SINGLE 2

// Target register fields
`define ONVED_TGT_ADDR_HI 7
`define ONVED_TGT_ADDR_LO 0
`define ONVED_TGT_MODE_HI 11
`define ONVED_TGT_MODE_LO 8
`define ONVED_TGT_DUM_HI 15
`define ONVED_TGT_DUM_LO 12

// Status fields
`define ONVED_ST_PUB 0
`define ONVED_ST_CONFLICT 1
`define ONVED_ST_STICKY 2
`define ONVED_ST_SINGLE 3
`define ONVED_ST_NORD 4
`define ONVED_ST_NOWR 5
`define ONVED_ST_DUM_HI 11
`define ONVED_ST_DUM_LO 8
`define ONVED_BIT_PUB_GO 0

// Reset values and codes
`define ONVED_CTRL_RST 32'h0000_0000
`define ONVED_TGT_RST 16'h0000
`define ONVED_CMDS_RST 16'h0000
`define ONVED_DESC_RST 32'h0000_0000
`define ONVED_CMD_NONE 8'h00

`endif

/* onved_pkg.sv */
package onved_pkg;

  // Address width of the device, selects legal byte placement
  typedef enum logic [1:0] {
    ONVED_AW_8 = 2'b00,
    ONVED_AW_24 = 2'b01,
    ONVED_AW_32 = 2'b11
  } onved_aw_e;

  // Bus answer sequencer
  typedef enum logic [1:0] {
    ONVED_BUS_IDLE = 2'b00,
    ONVED_BUS_ACK = 2'b01
  } onved_bus_e;

endpackage : onved_pkg

/* onved_encoder.sv */
`include "onved_regs.svh"

module onved_encoder (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic load_in,
  input wire logic [31:0] ctrl_in,
  input wire logic [15:0] target_in,
  input wire logic [15:0] cmds_in,
  output logic [31:0] word_out
);

  logic [31:0] word_d;
  logic [31:0] word_q;
  logic aw_ok_byte1;

  // Second-byte placement is only meaningful above 8-bit addressing
  assign aw_ok_byte1 = onved_pkg::onved_aw_e'(ctrl_in[`ONVED_AW_HI:`ONVED_AW_LO])
                       != onved_pkg::ONVED_AW_8;

  // Assemble the word; an absent enable bit publishes all zeros
  always_comb begin
    word_d = `ONVED_DESC_RST;
    if (ctrl_in[`ONVED_BIT_AVAIL]) begin
      word_d[`ONVED_BIT_AVAIL] = 1'b1;
      word_d[`ONVED_BIT_POL] = ctrl_in[`ONVED_BIT_POL];
      word_d[`ONVED_BIT_OTP] = ctrl_in[`ONVED_BIT_OTP];
      word_d[`ONVED_BIT_ADDRD] = ctrl_in[`ONVED_BIT_ADDRD];
      word_d[`ONVED_BIT_BYTE1] = ctrl_in[`ONVED_BIT_BYTE1] & aw_ok_byte1;
      word_d[`ONVED_POS_HI:`ONVED_POS_LO] = ctrl_in[`ONVED_POS_HI:`ONVED_POS_LO];
      if (ctrl_in[`ONVED_BIT_ADDRD]) begin
        word_d[`ONVED_LOC_HI:`ONVED_LOC_LO] = target_in[`ONVED_TGT_ADDR_HI:`ONVED_TGT_ADDR_LO];
      end else begin
        word_d[`ONVED_BIT_MODE_OD:`ONVED_BIT_MODE_QS] =
          target_in[`ONVED_TGT_MODE_HI:`ONVED_TGT_MODE_LO];
        word_d[`ONVED_DUM_HI:`ONVED_DUM_LO] = target_in[`ONVED_TGT_DUM_HI:`ONVED_TGT_DUM_LO];
      end
      word_d[`ONVED_RDCMD_HI:`ONVED_RDCMD_LO] = cmds_in[`ONVED_RDCMD_HI:`ONVED_RDCMD_LO];
      word_d[`ONVED_WRCMD_HI:`ONVED_WRCMD_LO] = cmds_in[`ONVED_WRCMD_HI:`ONVED_WRCMD_LO];
    end
  end

  // Snapshot only on load, so a reader never sees a half-edited word
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_q <= `ONVED_DESC_RST;
    end else if (load_in) begin
      word_q <= word_d;
    end
  end

  assign word_out = word_q;

endmodule : onved_encoder

/* onved_desc_slave.sv */
// Register access over Wishbone and the register offsets were chosen for this implementation.
`include "onved_regs.svh"

module onved_desc_slave (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic [31:0] desc_word_out,
  output logic desc_valid_out,
  output logic single_line_no_dummy_out
);

  // Merge write data into a register under the byte enables
  function automatic logic [31:0] onved_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : onved_merge

  // True when the current byte placement is illegal for the address width
  function automatic logic onved_conflict(input logic [31:0] ctrl);
    logic res;
    res = ctrl[`ONVED_BIT_BYTE1] &
          (onved_pkg::onved_aw_e'(ctrl[`ONVED_AW_HI:`ONVED_AW_LO]) == onved_pkg::ONVED_AW_8);
    return res;
  endfunction : onved_conflict

  onved_pkg::onved_bus_e bus_state_q;
  onved_pkg::onved_bus_e bus_state_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] ctrl_q;
  logic [15:0] target_q;
  logic [15:0] cmds_q;
  logic pub_valid_q;
  logic sticky_q;
  logic single_q;
  logic [31:0] status_w;
  logic [31:0] desc_w;
  logic bus_req;
  logic bus_commit;
  logic wr_ctrl;
  logic wr_target;
  logic wr_cmds;
  logic wr_status;
  logic wr_publish;
  logic publish_go;
  logic conflict_now;
  logic [31:0] target_merged;
  logic [31:0] cmds_merged;

  // A new request is seen only while idle, so one transfer gets one ack
  assign bus_req = wb_cyc_in & wb_stb_in & (bus_state_q == onved_pkg::ONVED_BUS_IDLE);

  // Writes land at the edge where the master samples ack high
  assign bus_commit = wb_cyc_in & wb_stb_in & wb_we_in &
                      (bus_state_q == onved_pkg::ONVED_BUS_ACK);

  // Write strobes per register; unmapped addresses fall through silently
  assign wr_ctrl = bus_commit & (wb_adr_in == `ONVED_OFS_CTRL);
  assign wr_target = bus_commit & (wb_adr_in == `ONVED_OFS_TARGET);
  assign wr_cmds = bus_commit & (wb_adr_in == `ONVED_OFS_CMDS);
  assign wr_status = bus_commit & (wb_adr_in == `ONVED_OFS_STATUS);
  assign wr_publish = bus_commit & (wb_adr_in == `ONVED_OFS_PUBLISH);
  assign publish_go = wr_publish & wb_sel_in[0] & wb_dat_in[`ONVED_BIT_PUB_GO];

  // Narrow registers are merged on a zero-extended copy
  assign target_merged = onved_merge({16'h0000, target_q}, wb_dat_in, wb_sel_in);
  assign cmds_merged = onved_merge({16'h0000, cmds_q}, wb_dat_in, wb_sel_in);

  // Live check of the staged control value
  // placement conflict check
  assign conflict_now = onved_conflict(ctrl_q);

  // Bus sequencer: idle, then one ack cycle, then idle again
  always_comb begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      onved_pkg::ONVED_BUS_IDLE: begin
        if (bus_req) begin
          bus_state_d = onved_pkg::ONVED_BUS_ACK;
        end
      end
      onved_pkg::ONVED_BUS_ACK: begin
        bus_state_d = onved_pkg::ONVED_BUS_IDLE;
      end
      default: begin
        bus_state_d = onved_pkg::ONVED_BUS_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_state_q <= onved_pkg::ONVED_BUS_IDLE;
    end else begin
      bus_state_q <= bus_state_d;
    end
  end

  // Ack rises one cycle after the request and drops the next cycle
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  // Status view of the block's own state
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[`ONVED_ST_PUB] = pub_valid_q;
    status_w[`ONVED_ST_CONFLICT] = conflict_now;
    status_w[`ONVED_ST_STICKY] = sticky_q;
    status_w[`ONVED_ST_SINGLE] = single_q;
    status_w[`ONVED_ST_NORD] = desc_w[`ONVED_RDCMD_HI:`ONVED_RDCMD_LO] == `ONVED_CMD_NONE;
    status_w[`ONVED_ST_NOWR] = desc_w[`ONVED_WRCMD_HI:`ONVED_WRCMD_LO] == `ONVED_CMD_NONE;
    // Published dummy count, meaningful only for direct access
    if (!desc_w[`ONVED_BIT_ADDRD]) begin
      status_w[`ONVED_ST_DUM_HI:`ONVED_ST_DUM_LO] = desc_w[`ONVED_DUM_HI:`ONVED_DUM_LO];
    end
  end

  // Read mux; unmapped offsets and publish answer zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (wb_adr_in)
      `ONVED_OFS_DESC: begin
        rdata_d = desc_w;
      end
      `ONVED_OFS_CTRL: begin
        rdata_d = ctrl_q;
      end
      `ONVED_OFS_TARGET: begin
        rdata_d = {16'h0000, target_q};
      end
      `ONVED_OFS_CMDS: begin
        rdata_d = {16'h0000, cmds_q};
      end
      `ONVED_OFS_STATUS: begin
        rdata_d = status_w;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data is captured with the ack so it stands for the ack cycle
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_req) begin
      rdata_q <= rdata_d;
    end
  end

  // Control register: descriptor flags, address width, single-line support
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= `ONVED_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= onved_merge(ctrl_q, wb_dat_in, wb_sel_in);
    end
  end

  // Target register: local address, or mode flags and dummy count
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      target_q <= `ONVED_TGT_RST;
    end else if (wr_target) begin
      target_q <= target_merged[15:0];
    end
  end

  // Command codes register
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmds_q <= `ONVED_CMDS_RST;
    end else if (wr_cmds) begin
      cmds_q <= cmds_merged[15:0];
    end
  end

  // Published flag goes high on the first publish and stays
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pub_valid_q <= 1'b0;
    end else if (publish_go) begin
      pub_valid_q <= 1'b1;
    end
  end

  // Sticky conflict: publishing an illegal placement; set beats clear
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sticky_q <= 1'b0;
    end else if (publish_go & conflict_now) begin
      sticky_q <= 1'b1;
    end else if (wr_status & wb_sel_in[0] & wb_dat_in[`ONVED_ST_STICKY]) begin
      sticky_q <= 1'b0;
    end
  end

  // Single-line support is frozen with the descriptor it belongs to
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      single_q <= 1'b0;
    end else if (publish_go) begin
      single_q <= ctrl_q[`ONVED_BIT_SINGLE] & ctrl_q[`ONVED_BIT_AVAIL];
    end
  end

  // Descriptor builder; byte placement is masked at 8-bit width inside
  onved_encoder u_encoder (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .load_in(publish_go),
    .ctrl_in(ctrl_q),
    .target_in(target_q),
    .cmds_in(cmds_q),
    .word_out(desc_w)
  );

  // Outputs come straight from flops
  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdata_q;
  assign desc_word_out = desc_w;
  assign desc_valid_out = pub_valid_q;
  assign single_line_no_dummy_out = single_q;

endmodule : onved_desc_slave

/* onved_host_model.sv */
module onved_host_model (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [31:0] word_in,
  input wire logic valid_in,
  input wire logic single_in,
  output logic [31:0] addr_out,
  output logic [3:0] dummy_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Host view of the published word, a cycle behind it
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_out <= 32'h0;
      dummy_out <= 4'h0;
    end else if (!valid_in || !word_in[31]) begin
      addr_out <= 32'h0;
      dummy_out <= 4'h0;
    end else begin
      if (!word_in[28]) begin
        addr_out <= 32'h0;
      end else if (word_in[27]) begin
        addr_out <= {16'h0, word_in[23:16], 8'h0};
      end else begin
        addr_out <= {24'h0, word_in[23:16]};
      end
      dummy_out <= (single_in || word_in[28]) ? 4'h0 : word_in[19:16];
    end
  end
endmodule : onved_host_model

/* onved_desc_chk.sv */
module onved_desc_chk (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic [31:0] desc_word_out,
  input wire logic desc_valid_out,
  input wire logic single_line_no_dummy_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // Publish commit edge, kept as a flag so its past can be asked for
  logic pub_now;
  logic pub_q;
  assign pub_now = wb_ack_out && wb_we_in && wb_adr_in == 8'h14 && wb_sel_in[0] && wb_dat_in[0];
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pub_q <= 1'b0;
    end else begin
      pub_q <= pub_now;
    end
  end

  // Request taken while the slave is idle
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_pub;
    pub_now;
  endsequence

  chk_ack_one_wait: assert property (s_req |=> wb_ack_out) else $error("ack not one cycle later");
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held too long");
  chk_ack_has_req: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  chk_desc_commit: assert property ($changed(desc_word_out) |-> pub_q)
    else $error("descriptor changed without publish");
  chk_valid_set: assert property (s_pub |=> desc_valid_out ##1 desc_valid_out)
    else $error("valid not set by publish");
  chk_absent_zero: assert property (!desc_word_out[31] |-> desc_word_out == 32'h0)
    else $error("absent bit with fields set");
  chk_single_avail: assert property (single_line_no_dummy_out |-> desc_word_out[31])
    else $error("single line without enable bit");
  chk_desc_read: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h00
    |-> wb_dat_out == desc_word_out) else $error("descriptor read mismatch");
  chk_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in > 8'h14
    |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
endmodule : onved_desc_chk

bind onved_desc_slave onved_desc_chk u_chk (
  .core_clk_in(core_clk_in),
  .rst_b_in(rst_b_in),
  .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out),
  .desc_word_out(desc_word_out),
  .desc_valid_out(desc_valid_out),
  .single_line_no_dummy_out(single_line_no_dummy_out)
);

/* tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [31:0] desc_word;
  logic desc_valid;
  logic single;
  logic [31:0] host_addr;
  logic [3:0] host_dummy;
  logic [31:0] c, t, m, w, q;
  logic [31:0] corner_c [4] = '{32'h7f00_0007, 32'h8800_0000, 32'h9500_0003, 32'hc700_0005};
  int fails = 0;
  int samples_checked = 0;
  int i;

  always #5 core_clk_in = ~core_clk_in;

  onved_desc_slave dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
    .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .desc_word_out(desc_word),
    .desc_valid_out(desc_valid), .single_line_no_dummy_out(single));
  onved_host_model u_host (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .word_in(desc_word),
    .valid_in(desc_valid), .single_in(single), .addr_out(host_addr), .dummy_out(host_dummy));

  task automatic report_and_stop;
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= s;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      report_and_stop;
    end
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk_in);
  endtask : wb_xfer

  // Word the device should publish for the staged registers
  function automatic logic [31:0] exp_desc(input logic [31:0] c, input logic [15:0] t,
                                           input logic [15:0] m);
    logic [31:0] r;
    r = 32'h0;
    if (c[31]) begin
      r = {c[31:28], c[27] && (c[1:0] != 2'b00), c[26:24], 8'h0, m};
      r[23:16] = c[28] ? t[7:0] : {t[11:8], t[15:12]};
    end
    return r;
  endfunction : exp_desc

  function automatic logic [31:0] exp_stat(input logic [31:0] c, input logic [31:0] r);
    logic [31:0] s;
    s = 32'h1;
    s[1] = c[27] && c[1:0] == 2'b00;
    s[2] = s[1];
    s[3] = c[2] && c[31];
    s[4] = r[15:8] == 8'h00;
    s[5] = r[7:0] == 8'h00;
    s[11:8] = (r[31] && !r[28]) ? r[19:16] : 4'h0;
    return s;
  endfunction : exp_stat

  // Host address: local byte in byte 1 only where legal; direct access sends none
  function automatic logic [31:0] exp_addr(input logic [31:0] c, input logic [15:0] t);
    logic [31:0] a;
    a = 32'h0;
    if (c[31] && c[28]) begin
      a = (c[27] && c[1:0] != 2'b00) ? {16'h0, t[7:0], 8'h0} : {24'h0, t[7:0]};
    end
    return a;
  endfunction : exp_addr

  // Host dummy count: listed count for direct access unless single-line is offered
  function automatic logic [3:0] exp_dum(input logic [31:0] c, input logic [15:0] t);
    logic [3:0] d;
    d = 4'h0;
    if (c[31] && !c[28] && !c[2]) begin
      d = t[15:12];
    end
    return d;
  endfunction : exp_dum

  initial begin
    void'($urandom(6));
    repeat (16) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    @(posedge core_clk_in);
    check({31'h0, desc_valid}, 32'h0);
    // Registers start at zero; status flags both empty command codes
    for (i = 0; i < 6; i++) begin
      wb_xfer(1'b0, 8'(i * 4), 32'h0, 4'hf, q);
      check(q, (i == 4) ? 32'h0000_0030 : 32'h0);
    end
    // Read-only, unmapped and byte-lane accesses
    wb_xfer(1'b1, 8'h00, 32'hffff_ffff, 4'hf, q);
    wb_xfer(1'b1, 8'h40, 32'hffff_ffff, 4'hf, q);
    wb_xfer(1'b0, 8'h40, 32'h0, 4'hf, q);
    check(q, 32'h0);
    wb_xfer(1'b0, 8'h00, 32'h0, 4'hf, q);
    check(q, 32'h0);
    wb_xfer(1'b1, 8'h0c, 32'hffff_1234, 4'hf, q);
    wb_xfer(1'b1, 8'h0c, 32'h0000_ab77, 4'h2, q);
    wb_xfer(1'b0, 8'h0c, 32'h0, 4'hf, q);
    check(q, 32'h0000_ab34);
    // Corner words first, then random ones
    for (i = 0; i < 40; i++) begin
      c = (i < 4) ? corner_c[i] : ($urandom() & 32'hff00_0007);
      t = $urandom() & 32'h0000_ffff;
      m = (i == 2) ? 32'h0 : ($urandom() & 32'h0000_ffff);
      if (i == 3) t[15:8] = 8'hff;
      // Last word is present, so a stray publish of zeros later shows up
      if (i == 39) c[31] = 1'b1;
      wb_xfer(1'b1, 8'h04, c, 4'hf, q);
      wb_xfer(1'b1, 8'h08, t, 4'hf, q);
      wb_xfer(1'b1, 8'h0c, m, 4'hf, q);
      wb_xfer(1'b1, 8'h10, 32'h4, 4'hf, q);
      wb_xfer(1'b1, 8'h14, 32'h1, 4'h1, q);
      w = exp_desc(c, t[15:0], m[15:0]);
      wb_xfer(1'b0, 8'h00, 32'h0, 4'hf, q);
      check(q, w);
      check(desc_word, w);
      check({31'h0, desc_valid}, 32'h1);
      wb_xfer(1'b0, 8'h10, 32'h0, 4'hf, q);
      check(q, exp_stat(c, w));
      check({31'h0, single}, {31'h0, c[2] & c[31]});
      check(host_addr, exp_addr(c, t[15:0]));
      check({28'h0, host_dummy}, {28'h0, exp_dum(c, t[15:0])});
    end
    // Publish with its byte lane off leaves the word alone
    wb_xfer(1'b1, 8'h04, 32'h0, 4'hf, q);
    wb_xfer(1'b1, 8'h14, 32'hffff_ffff, 4'he, q);
    check(desc_word, w);
    report_and_stop;
  end
endmodule : tb_top
